// ==== src/pfb_bridge.sv ====
// Purpose: full-bridge steering with auto-shutdown and APB registers
// Assumes: inputs synchronous to CLK_SYS; external port logic honours output enables
// Notes:   shutdown flag is set by hardware and cleared by software writing zero
//
// Contract
// - full-bridge mode drives all four outputs a, b, c and d.
// - forward: a active, d modulated, b and c inactive.
// - reverse: c active, b modulated, a and d inactive.
// - bit 7 of shutdown control shows a shutdown has occurred.
// - source code 000 disables auto-shutdown entirely.
// - codes 001, 010, 011 trigger on comparator one, two, either high.
// - code 100 fault pin low; 101 adds comparator one; 110 adds two.
// - in shutdown a and c follow bits 3-2: low, high or high impedance.
// - in shutdown b and d follow bits 1-0: low, high or high impedance.
`timescale 1ns/1ps
module pfb_bridge (
  input  wire logic        CLK_SYS,
  input  wire logic        RESETN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        PWM_IN,
  input  wire logic        TIMER_TICK,
  input  wire logic        COMPARATOR_ONE,
  input  wire logic        COMPARATOR_TWO,
  input  wire logic        FAULT_INPUT_PIN,
  output logic      [3:0]  BRIDGE_OUT,
  output logic      [3:0]  BRIDGE_OE,
  output logic             IRQ
);

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [3:0]  bridge;
    logic [1:0]  stat;
    logic [1:0]  mask;
    logic [3:0]  out;
    logic [3:0]  oe;
    logic [31:0] rdata;
    logic        slverr;
  } pfb_state_t;

  pfb_state_t st_reg;
  pfb_state_t st_next;

  logic       trigger;
  logic [3:0] steer_level;
  logic       setup;
  logic       access;
  logic       wr;
  logic       shut_now;

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  pfb_trigger u_trigger (
    .clk             (CLK_SYS),
    .rst_n           (RESETN),
    .source_select   (st_reg.ctrl[pfb_pkg::SRC_MSB:pfb_pkg::SRC_LSB]),
    .sync_enable     (st_reg.bridge[pfb_pkg::BR_SYNC_BIT]),
    .timer_tick      (TIMER_TICK),
    .comparator_one  (COMPARATOR_ONE),
    .comparator_two  (COMPARATOR_TWO),
    .fault_input_pin (FAULT_INPUT_PIN),
    .trigger         (trigger)
  );

  pfb_steer u_steer (
    .reverse    (st_reg.bridge[pfb_pkg::BR_REV_BIT]),
    .active_low (st_reg.bridge[pfb_pkg::BR_POL_BIT]),
    .pwm        (PWM_IN),
    .level      (steer_level)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  function automatic logic pfb_mapped(input logic [7:0] a);
    return (a == pfb_pkg::ADDR_SHDN_CTRL) || (a == pfb_pkg::ADDR_BRIDGE) ||
           (a == pfb_pkg::ADDR_IRQ_STAT) || (a == pfb_pkg::ADDR_IRQ_MASK);
  endfunction : pfb_mapped

  assign setup  = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;
  assign wr     = access && PWRITE && PSTRB[0] && pfb_mapped(PADDR);

  // shutdown holds while the flag is set or the trigger is true right now
  assign shut_now = trigger || st_reg.ctrl[pfb_pkg::SHDN_FLAG_BIT];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] ev;
    logic [1:0] ac_st;
    logic [1:0] bd_st;
    ev      = 2'h0;
    ac_st   = 2'h0;
    bd_st   = 2'h0;
    st_next = st_reg;

    // register writes
    if (wr) begin
      unique case (PADDR)
        pfb_pkg::ADDR_SHDN_CTRL: st_next.ctrl = PWDATA[7:0];
        pfb_pkg::ADDR_BRIDGE:    st_next.bridge = PWDATA[3:0];
        pfb_pkg::ADDR_IRQ_STAT:  st_next.stat = st_reg.stat & ~PWDATA[1:0];
        pfb_pkg::ADDR_IRQ_MASK:  st_next.mask = PWDATA[1:0];
        default: ;
      endcase
    end

    // hardware sets the flag; a set beats a software clear in the same cycle
    if (trigger) begin
      st_next.ctrl[pfb_pkg::SHDN_FLAG_BIT] = 1'b1;
    end

    ev[pfb_pkg::IRQ_ENTER_BIT] = trigger && !st_reg.ctrl[pfb_pkg::SHDN_FLAG_BIT];
    ev[pfb_pkg::IRQ_LEAVE_BIT] = st_reg.ctrl[pfb_pkg::SHDN_FLAG_BIT] &&
                                 !st_next.ctrl[pfb_pkg::SHDN_FLAG_BIT];
    st_next.stat = st_next.stat | ev;

    // output stage
    ac_st = st_next.ctrl[pfb_pkg::AC_MSB:pfb_pkg::AC_LSB];
    bd_st = st_next.ctrl[pfb_pkg::BD_MSB:pfb_pkg::BD_LSB];
    if (!st_next.bridge[pfb_pkg::BR_EN_BIT]) begin
      st_next.out = 4'h0;
      st_next.oe  = 4'h0;
    end else if (trigger || st_next.ctrl[pfb_pkg::SHDN_FLAG_BIT]) begin
      st_next.out[0] = ac_st[0];
      st_next.out[2] = ac_st[0];
      st_next.oe[0]  = !ac_st[1];
      st_next.oe[2]  = !ac_st[1];
      st_next.out[1] = bd_st[0];
      st_next.out[3] = bd_st[0];
      st_next.oe[1]  = !bd_st[1];
      st_next.oe[3]  = !bd_st[1];
    end else begin
      st_next.out = steer_level;
      st_next.oe  = 4'hF;
    end

    // read data captured during setup, presented in access
    if (setup) begin
      st_next.slverr = !pfb_mapped(PADDR);
      st_next.rdata  = 32'h0000_0000;
      unique case (PADDR)
        pfb_pkg::ADDR_SHDN_CTRL: st_next.rdata[7:0] = st_reg.ctrl;
        pfb_pkg::ADDR_BRIDGE:    st_next.rdata[3:0] = st_reg.bridge;
        pfb_pkg::ADDR_IRQ_STAT:  st_next.rdata[1:0] = st_reg.stat;
        pfb_pkg::ADDR_IRQ_MASK:  st_next.rdata[1:0] = st_reg.mask;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      st_reg        <= '0;
      st_reg.ctrl   <= pfb_pkg::SHDN_CTRL_RESET;
      st_reg.bridge <= pfb_pkg::BRIDGE_RESET;
      st_reg.stat   <= pfb_pkg::IRQ_RESET;
      st_reg.mask   <= pfb_pkg::IRQ_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // outputs are registered, so the pins follow the trigger one edge later
  assign BRIDGE_OUT = st_reg.out;
  assign BRIDGE_OE  = st_reg.oe;
  assign PRDATA     = st_reg.rdata;
  assign PREADY     = 1'b1;
  assign PSLVERR    = access && st_reg.slverr;
  assign IRQ        = |(st_reg.stat & st_reg.mask);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence trig_seen;
    trigger && st_reg.bridge[pfb_pkg::BR_EN_BIT] && $stable(st_reg.bridge);
  endsequence

  // flag may also be written to one by software, so entry is judged by the trigger
  sequence shut_entry;
    trigger && !st_reg.ctrl[pfb_pkg::SHDN_FLAG_BIT];
  endsequence

  sequence shut_exit;
    st_reg.ctrl[pfb_pkg::SHDN_FLAG_BIT] ##1 !st_reg.ctrl[pfb_pkg::SHDN_FLAG_BIT];
  endsequence

  // comparator held off: no tick and no bus write, so the latch cannot move
  sequence sync_wait;
    st_reg.ctrl[pfb_pkg::SRC_MSB:pfb_pkg::SRC_LSB] == pfb_pkg::SRC_C1 &&
      st_reg.bridge[pfb_pkg::BR_SYNC_BIT] && !TIMER_TICK && !trigger && !wr;
  endsequence

  flag_set_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    trigger |=> st_reg.ctrl[pfb_pkg::SHDN_FLAG_BIT])
    else $error("shutdown flag not set after trigger");

  flag_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (st_reg.ctrl[pfb_pkg::SHDN_FLAG_BIT] && !wr) |=> st_reg.ctrl[pfb_pkg::SHDN_FLAG_BIT])
    else $error("shutdown flag dropped without a write");

  // ----------------------------------------------------------------
  // source decode checks
  // ----------------------------------------------------------------
  // comparator terms checked unsynchronised only; the latch delays them otherwise
  src_off_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (st_reg.ctrl[6:4] == pfb_pkg::SRC_OFF) |-> !trigger)
    else $error("trigger with source disabled");

  comp_one_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (st_reg.ctrl[6:4] == pfb_pkg::SRC_C1 && !st_reg.bridge[3] && COMPARATOR_ONE) |-> trigger)
    else $error("comparator one ignored");

  comp_two_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (st_reg.ctrl[pfb_pkg::SRC_MSB:pfb_pkg::SRC_LSB] == pfb_pkg::SRC_C2 &&
     !st_reg.bridge[pfb_pkg::BR_SYNC_BIT] && COMPARATOR_TWO) |-> trigger)
    else $error("comparator two ignored");

  comp_either_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (st_reg.ctrl[pfb_pkg::SRC_MSB:pfb_pkg::SRC_LSB] == pfb_pkg::SRC_C1_C2 &&
     !st_reg.bridge[pfb_pkg::BR_SYNC_BIT] && (COMPARATOR_ONE || COMPARATOR_TWO)) |-> trigger)
    else $error("either comparator ignored");

  fault_pin_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (st_reg.ctrl[6:4] == pfb_pkg::SRC_FLT) |-> (trigger == !FAULT_INPUT_PIN))
    else $error("fault pin decode wrong");

  flt_one_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (st_reg.ctrl[pfb_pkg::SRC_MSB:pfb_pkg::SRC_LSB] == pfb_pkg::SRC_FLT_C1 &&
     !st_reg.bridge[pfb_pkg::BR_SYNC_BIT] && (!FAULT_INPUT_PIN || COMPARATOR_ONE)) |-> trigger)
    else $error("fault or comparator one ignored");

  flt_two_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (st_reg.ctrl[pfb_pkg::SRC_MSB:pfb_pkg::SRC_LSB] == pfb_pkg::SRC_FLT_C2 &&
     !st_reg.bridge[pfb_pkg::BR_SYNC_BIT] && (!FAULT_INPUT_PIN || COMPARATOR_TWO)) |-> trigger)
    else $error("fault or comparator two ignored");

  sync_wait_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    sync_wait |=> !trigger)
    else $error("comparator shutdown not held for timer tick");

  // ----------------------------------------------------------------
  // output and interrupt checks
  // ----------------------------------------------------------------
  ac_shut_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (trig_seen ##1 (st_reg.ctrl[3:2] == $past(st_reg.ctrl[3:2]) && st_reg.bridge[pfb_pkg::BR_EN_BIT])) |->
      (BRIDGE_OE[0] == !st_reg.ctrl[3] && BRIDGE_OUT[2] == st_reg.ctrl[2]))
    else $error("a/c shutdown state wrong");

  bd_shut_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (trig_seen ##1 (st_reg.ctrl[1:0] == $past(st_reg.ctrl[1:0]) && st_reg.bridge[pfb_pkg::BR_EN_BIT])) |->
      (BRIDGE_OE[3] == !st_reg.ctrl[1] && BRIDGE_OUT[1] == st_reg.ctrl[0]))
    else $error("b/d shutdown state wrong");

  fwd_steer_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (!shut_now && st_reg.bridge == 4'h1 && !trigger && $stable(st_reg.bridge) && !wr) |=>
      (BRIDGE_OUT[0] && !BRIDGE_OUT[1] && !BRIDGE_OUT[2] && BRIDGE_OE == 4'hF))
    else $error("forward steering wrong");

  fwd_mod_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (!shut_now && st_reg.bridge == 4'h1 && !wr) |=> (BRIDGE_OUT[3] == $past(PWM_IN)))
    else $error("forward modulation not on output d");

  rev_steer_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (!shut_now && st_reg.bridge == 4'h3 && !wr) |=>
      (!BRIDGE_OUT[0] && BRIDGE_OUT[2] && !BRIDGE_OUT[3] && BRIDGE_OE == 4'hF))
    else $error("reverse steering wrong");

  rev_mod_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (!shut_now && st_reg.bridge == 4'h3 && !wr) |=> (BRIDGE_OUT[1] == $past(PWM_IN)))
    else $error("reverse modulation not on output b");

  pol_inv_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (!shut_now && st_reg.bridge == 4'h5 && !wr) |=>
      (!BRIDGE_OUT[0] && BRIDGE_OUT[1] && BRIDGE_OUT[2] && BRIDGE_OE == 4'hF))
    else $error("active-low forward levels wrong");

  off_quiet_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (!st_reg.bridge[pfb_pkg::BR_EN_BIT] && !wr) |=> (BRIDGE_OUT == 4'h0 && BRIDGE_OE == 4'h0))
    else $error("disabled bridge still driving");

  shut_same_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (trig_seen and (st_reg.ctrl[3:0] == 4'h0 && !wr)) |=> (BRIDGE_OUT == 4'h0))
    else $error("outputs not shut with flag");

  enter_stat_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    shut_entry |=> st_reg.stat[pfb_pkg::IRQ_ENTER_BIT])
    else $error("shutdown entry not recorded");

  leave_stat_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    shut_exit |-> st_reg.stat[pfb_pkg::IRQ_LEAVE_BIT])
    else $error("shutdown exit not recorded");

endmodule : pfb_bridge

// ==== src/pfb_pkg.sv ====
// Purpose: shared constants for the full-bridge steering and auto-shutdown block
// Assumes: APB slave, 32-bit data, one word per register
// Notes:   register offsets are byte addresses
package pfb_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SHDN_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BRIDGE    = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h0C;

  localparam logic [7:0] SHDN_CTRL_RESET = 8'h00;
  localparam logic [3:0] BRIDGE_RESET    = 4'h0;
  localparam logic [1:0] IRQ_RESET       = 2'h0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SHDN_FLAG_BIT = 7;
  localparam int SRC_MSB       = 6;
  localparam int SRC_LSB       = 4;
  localparam int AC_MSB        = 3;
  localparam int AC_LSB        = 2;
  localparam int BD_MSB        = 1;
  localparam int BD_LSB        = 0;
  // bridge control: bit0 enable, bit1 reverse, bit2 active-low polarity, bit3 comparator sync enable
  localparam int BR_EN_BIT     = 0;
  localparam int BR_REV_BIT    = 1;
  localparam int BR_POL_BIT    = 2;
  localparam int BR_SYNC_BIT   = 3;
  // interrupt bits: bit0 shutdown entered, bit1 shutdown left
  localparam int IRQ_ENTER_BIT = 0;
  localparam int IRQ_LEAVE_BIT = 1;

  // ----------------------------------------------------------------
  // source codes and pair states
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_OFF      = 3'h0;
  localparam logic [2:0] SRC_C1       = 3'h1;
  localparam logic [2:0] SRC_C2       = 3'h2;
  localparam logic [2:0] SRC_C1_C2    = 3'h3;
  localparam logic [2:0] SRC_FLT      = 3'h4;
  localparam logic [2:0] SRC_FLT_C1   = 3'h5;
  localparam logic [2:0] SRC_FLT_C2   = 3'h6;
  localparam logic [2:0] SRC_FLT_ALL  = 3'h7;

  localparam logic [1:0] PAIR_LOW  = 2'h0;
  localparam logic [1:0] PAIR_HIGH = 2'h1;

endpackage : pfb_pkg

// ==== src/pfb_trigger.sv ====
// Purpose: decode the selected shutdown source into one trigger level
// Assumes: comparator and fault inputs synchronous to the clock
// Notes:   comparator path may be delayed by the timer clock enable
`timescale 1ns/1ps
module pfb_trigger (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] source_select,
  input  wire logic       sync_enable,
  input  wire logic       timer_tick,
  input  wire logic       comparator_one,
  input  wire logic       comparator_two,
  input  wire logic       fault_input_pin,
  output logic            trigger
);

  typedef struct packed {
    logic c1;
    logic c2;
  } pfb_trig_state_t;

  pfb_trig_state_t st_reg;
  pfb_trig_state_t st_next;
  logic            c1_eff;
  logic            c2_eff;

  // ----------------------------------------------------------------
  // comparator resynchronisation
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    if (timer_tick) begin
      st_next.c1 = comparator_one;
      st_next.c2 = comparator_two;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign c1_eff = sync_enable ? st_reg.c1 : comparator_one;
  assign c2_eff = sync_enable ? st_reg.c2 : comparator_two;

  // ----------------------------------------------------------------
  // source decode
  // ----------------------------------------------------------------
  function automatic logic pfb_decode(input logic [2:0] sel, input logic c1, input logic c2, input logic flt_n);
    logic r;
    r = 1'b0;
    unique case (sel)
      pfb_pkg::SRC_OFF:     r = 1'b0;
      pfb_pkg::SRC_C1:      r = c1;
      pfb_pkg::SRC_C2:      r = c2;
      pfb_pkg::SRC_C1_C2:   r = c1 | c2;
      pfb_pkg::SRC_FLT:     r = !flt_n;
      pfb_pkg::SRC_FLT_C1:  r = !flt_n | c1;
      pfb_pkg::SRC_FLT_C2:  r = !flt_n | c2;
      pfb_pkg::SRC_FLT_ALL: r = !flt_n | c1 | c2;
    endcase
    return r;
  endfunction : pfb_decode

  assign trigger = pfb_decode(source_select, c1_eff, c2_eff, fault_input_pin);

  sync_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sync_enable && !timer_tick) |=> $stable(st_reg))
    else $error("resync latch changed without timer tick");

endmodule : pfb_trigger

// ==== src/pfb_steer.sv ====
// Purpose: steer modulation onto the four bridge outputs
// Assumes: pwm input is the modulated signal, active high; inverted here when active_low is set
// Notes:   purely combinational; registered in the top
`timescale 1ns/1ps
module pfb_steer (
  input  wire logic       reverse,
  input  wire logic       active_low,
  input  wire logic       pwm,
  output logic      [3:0] level
);

  logic act;
  logic inact;
  logic mod;

  assign act   = !active_low;
  assign inact = active_low;
  assign mod   = pwm ^ active_low;

  // ----------------------------------------------------------------
  // direction mapping, bit order d c b a
  // ----------------------------------------------------------------
  always_comb begin
    if (reverse) begin
      level = {inact, act, mod, inact};
    end else begin
      level = {mod, inact, inact, act};
    end
  end

endmodule : pfb_steer

// ==== sim/pfb_switch_model.sv ====
// Purpose: external full-bridge power switches seen from the four bridge outputs
// Assumes: gate drivers hold a pull-down, so a released gate reads low
// Notes:   floating marks a gate that nobody drives, so high impedance stays visible
`timescale 1ns/1ps
module pfb_switch_model (
  input  wire logic [3:0] bridge_out,
  input  wire logic [3:0] bridge_oe,
  input  wire logic [3:0] pin_direction_bits,
  output logic      [3:0] gate,
  output logic      [3:0] floating
);
  // ----------------------------------------------------------------
  // pin resolution
  // ----------------------------------------------------------------
  logic [3:0] driven;
  // a pin reaches the switch only with its direction bit cleared
  assign driven   = bridge_oe & ~pin_direction_bits;
  // pull-down: a released gate turns its switch off instead of holding the last level
  assign gate     = bridge_out & driven;
  assign floating = ~driven;
endmodule : pfb_switch_model

// ==== sim/pfb_bridge_bench.sv ====
// Purpose: self-checking bench for the full-bridge steering and auto-shutdown block
// Assumes: APB answers with PREADY; outputs registered one cycle after inputs
// Notes:   pins are judged through the switch model, never from the design state
`timescale 1ns/1ps
module pfb_bridge_bench;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, irq;
  logic        pwm_in = 1'b0, timer_tick = 1'b0, comp_one = 1'b0, comp_two = 1'b0, fault_pin = 1'b1;
  logic [3:0]  bridge_out, bridge_oe, gate, floating;
  logic [31:0] rd;
  logic        err;
  logic [1:0]  ac, bd;
  logic        hit;
  int          bad_count = 0;
  int          comparisons = 0;

  always #4 clk_sys = ~clk_sys;

  pfb_bridge dut (.CLK_SYS(clk_sys), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PWM_IN(pwm_in), .TIMER_TICK(timer_tick), .COMPARATOR_ONE(comp_one), .COMPARATOR_TWO(comp_two),
    .FAULT_INPUT_PIN(fault_pin), .BRIDGE_OUT(bridge_out), .BRIDGE_OE(bridge_oe), .IRQ(irq));

  // direction bits all cleared by software so the bridge reaches the pins
  pfb_switch_model switches (.bridge_out(bridge_out), .bridge_oe(bridge_oe),
    .pin_direction_bits(4'h0), .gate(gate), .floating(floating));

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) bad_count++;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb_xfer

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_pins(input logic [7:0] exp);
    comparisons++;
    if ({floating, gate} !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, {floating, gate}, exp);
    end
  endtask : check_pins

  // bit0 a, bit1 b, bit2 c, bit3 d; result is {floating, gate}
  function automatic logic [7:0] exp_pins(logic rev, logic pwm, logic sd, logic [1:0] sac, logic [1:0] sbd);
    logic [3:0] g, f;
    if (sd) begin
      f = {sbd[1], sac[1], sbd[1], sac[1]};
      g = {sbd[0], sac[0], sbd[0], sac[0]} & ~f;
    end else begin
      f = 4'h0;
      g = rev ? {1'b0, 1'b1, pwm, 1'b0} : {pwm, 2'b00, 1'b1};
    end
    return {f, g};
  endfunction : exp_pins

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb_xfer(1'b0, 8'(i * 4), 32'h0);
      check_val(rd, 32'h0);
    end
    apb_xfer(1'b0, 8'h10, 32'h0);
    check_val({rd[30:0], err}, 32'h1);
    check_pins(8'hF0);
    // steering in both directions with both modulation levels
    for (int r = 0; r < 2; r++) begin
      for (int p = 0; p < 2; p++) begin
        apb_xfer(1'b1, pfb_pkg::ADDR_BRIDGE, 32'(r * 2 + 1));
        pwm_in <= p[0];
        @(posedge clk_sys);
        #1 check_pins(exp_pins(r[0], p[0], 1'b0, 2'h0, 2'h0));
      end
    end
    // active-low polarity inverts every level, modulation included
    apb_xfer(1'b1, pfb_pkg::ADDR_BRIDGE, 32'h5);
    @(posedge clk_sys);
    #1 check_pins(8'h06);
    // later expectations assume the modulation input idles low
    @(posedge clk_sys);
    pwm_in <= 1'b0;
    apb_xfer(1'b1, pfb_pkg::ADDR_BRIDGE, 32'h1);
    apb_xfer(1'b1, pfb_pkg::ADDR_IRQ_MASK, 32'h1);
    // every source code against each single trigger
    for (int code = 0; code < 8; code++) begin
      for (int s = 0; s < 3; s++) begin
        ac = 2'(code % 3);
        bd = 2'((code + 1) % 3);
        hit = code[s];
        apb_xfer(1'b1, pfb_pkg::ADDR_SHDN_CTRL, {24'h0, 1'b0, 3'(code), ac, bd});
        comp_one <= (s == 0); comp_two <= (s == 1); fault_pin <= (s != 2);
        @(posedge clk_sys);
        #1 check_pins(exp_pins(1'b0, 1'b0, hit, ac, bd));
        apb_xfer(1'b0, pfb_pkg::ADDR_SHDN_CTRL, 32'h0);
        check_val(rd, {24'h0, hit, 3'(code), ac, bd});
        check_val({31'h0, irq}, {31'h0, hit});
        comp_one <= 1'b0; comp_two <= 1'b0; fault_pin <= 1'b1;
        apb_xfer(1'b1, pfb_pkg::ADDR_SHDN_CTRL, {24'h0, 1'b0, 3'(code), ac, bd});
        apb_xfer(1'b0, pfb_pkg::ADDR_IRQ_STAT, 32'h0);
        check_val(rd, hit ? 32'h3 : 32'h0);
        apb_xfer(1'b1, pfb_pkg::ADDR_IRQ_STAT, 32'h3);
        #1 check_val({31'h0, irq}, 32'h0);
        check_pins(exp_pins(1'b0, 1'b0, 1'b0, 2'h0, 2'h0));
      end
    end
    // masked event still sets status but keeps the interrupt low
    apb_xfer(1'b1, pfb_pkg::ADDR_IRQ_MASK, 32'h0);
    apb_xfer(1'b1, pfb_pkg::ADDR_SHDN_CTRL, 32'h40);
    fault_pin <= 1'b0;
    apb_xfer(1'b0, pfb_pkg::ADDR_IRQ_STAT, 32'h0);
    check_val({rd[30:0], irq}, 32'h2);
    fault_pin <= 1'b1;
    apb_xfer(1'b1, pfb_pkg::ADDR_SHDN_CTRL, 32'h0);
    // comparator shutdown held off until the timer tick resamples it
    apb_xfer(1'b1, pfb_pkg::ADDR_BRIDGE, 32'h9);
    apb_xfer(1'b1, pfb_pkg::ADDR_SHDN_CTRL, 32'h10);
    comp_one <= 1'b1;
    repeat (3) @(posedge clk_sys);
    apb_xfer(1'b0, pfb_pkg::ADDR_SHDN_CTRL, 32'h0);
    check_val(rd, 32'h10);
    timer_tick <= 1'b1;
    @(posedge clk_sys);
    timer_tick <= 1'b0;
    apb_xfer(1'b0, pfb_pkg::ADDR_SHDN_CTRL, 32'h0);
    check_val(rd, 32'h90);
    check_pins(exp_pins(1'b0, 1'b0, 1'b1, 2'h0, 2'h0));
    wrap_up();
  end
endmodule : pfb_bridge_bench
